// *** inc/csie_pkg.sv ***
// Shared constants and types for the core state and interrupt entry unit.
package csie_pkg;
  // ------------------------------------------------------------------
  // Memory map and vectors
  // ------------------------------------------------------------------
  localparam logic [12:0] IO_HI = 13'h001F;
  localparam logic [12:0] PZ_HI = 13'h004F;
  localparam logic [12:0] RAM_HI = 13'h00FF;
  localparam logic [12:0] ROM_LO = 13'h0100;
  localparam logic [12:0] ROM_HI = 13'h10FF;
  localparam logic [12:0] SELF_LO = 13'h1F00;
  localparam logic [12:0] SELF_HI = 13'h1FEF;
  localparam logic [12:0] VEC_RESET = 13'h1FFE;
  localparam logic [12:0] VEC_SOFT = 13'h1FFC;
  localparam logic [12:0] VEC_EXT = 13'h1FFA;
  localparam logic [12:0] VEC_TIMER = 13'h1FF8;
  localparam logic [6:0] STACK_PAGE = 7'h03;
  localparam logic [5:0] SP_RESET = 6'h3F;
  // ------------------------------------------------------------------
  // Flag positions and reset values
  // ------------------------------------------------------------------
  localparam int CCR_C = 0;
  localparam int CCR_Z = 1;
  localparam int CCR_N = 2;
  localparam int CCR_I = 3;
  localparam int CCR_H = 4;
  localparam logic [4:0] CCR_RESET = 5'h08;
  localparam int CTRL_EXT_EN = 0;
  localparam int CTRL_LEVEL = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [4:0] REG_ACC = 5'h00;
  localparam logic [4:0] REG_IDX = 5'h04;
  localparam logic [4:0] REG_CCR = 5'h08;
  localparam logic [4:0] REG_SP = 5'h0C;
  localparam logic [4:0] REG_PC = 5'h10;
  localparam logic [4:0] REG_CTRL = 5'h14;
  localparam logic [4:0] REG_STAT = 5'h18;
  // ------------------------------------------------------------------
  // Stack frame bytes
  // ------------------------------------------------------------------
  localparam logic [2:0] BYTE_PCL = 3'h0;
  localparam logic [2:0] BYTE_PCH = 3'h1;
  localparam logic [2:0] BYTE_IDX = 3'h2;
  localparam logic [2:0] BYTE_ACC = 3'h3;
  localparam logic [2:0] BYTE_CCR = 3'h4;
  typedef enum logic [3:0] {
    OP_END = 4'h0, OP_SOFT_INT = 4'h1, OP_ADD = 4'h2, OP_ADC = 4'h3,
    OP_SUB = 4'h4, OP_AND = 4'h5, OP_LDA = 4'h6, OP_LDX = 4'h7,
    OP_ROL = 4'h8, OP_BTB = 4'h9, OP_STACK_RST = 4'hA, OP_CLI = 4'hB,
    OP_SEI = 4'hC, OP_CALL = 4'hD, OP_RTS = 4'hE, OP_INT_RET = 4'hF
  } csie_op_e;
  typedef enum logic [2:0] {
    RG_NONE = 3'h0, RG_IO = 3'h1, RG_PZROM = 3'h2, RG_RAM = 3'h3,
    RG_ROM = 3'h4, RG_SELF = 3'h5, RG_UVEC = 3'h6
  } csie_region_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_PUSH = 2'h1, ST_PULL = 2'h2, ST_VECTOR = 2'h3
  } csie_fsm_e;
endpackage : csie_pkg

// *** rtl/csie_core.sv ***
// Core register state, stacking and interrupt entry with an Avalon-MM view.
`timescale 1ns/1ps
module csie_core (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_CLK_EN,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_CMD_VALID,
  input wire logic [3:0] I_CMD_OP,
  input wire logic [7:0] I_CMD_DATA,
  input wire logic [12:0] I_CMD_ADDR,
  output logic O_CMD_READY,
  input wire logic I_IRQ_N,
  input wire logic [2:0] I_TIMER_FLAGS,
  input wire logic [2:0] I_TIMER_ENABLES,
  output logic [12:0] O_MEM_ADDR,
  output logic O_MEM_RD,
  output logic O_MEM_WR,
  output logic [7:0] O_MEM_WDATA,
  input wire logic [7:0] I_MEM_RDATA,
  output logic [2:0] O_MEM_REGION,
  output logic [7:0] O_ACC,
  output logic [7:0] O_IDX,
  output logic [4:0] O_CCR,
  output logic [7:0] O_SP,
  output logic [12:0] O_PC
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    csie_pkg::csie_fsm_e fsm;
    logic [1:0] ph;
    logic [2:0] k;
    logic [2:0] last;
    logic then_vec;
    logic [12:0] jmp;
    logic [12:0] vec;
    logic [4:0] vec_hi;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [4:0] condition_flag_reg;
    logic [5:0] sp;
    logic [12:0] pc;
    logic [1:0] ctrl;
    logic s1;
    logic s2;
    logic s3;
    logic irq_lvl;
    logic ext_latch;
    logic [12:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [2:0] region;
    logic ack;
    logic [31:0] rd_data;
  } csie_core_s;

  csie_core_s r;
  csie_core_s n;
  logic cmd_fire;
  logic fall;
  logic ext_req;
  logic tmr_req;
  logic [8:0] res9;
  logic [4:0] half;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Stack page is fixed, so a runaway stack wraps over its own oldest bytes.
  function automatic logic [12:0] stack_addr(input logic [5:0] p);
    stack_addr = {csie_pkg::STACK_PAGE, p};
  endfunction : stack_addr

  // Picks one byte of the five-byte frame.
  function automatic logic [7:0] frame_byte(input csie_core_s s, input logic [2:0] k);
    unique case (k)
      csie_pkg::BYTE_PCL: frame_byte = s.pc[7:0];
      csie_pkg::BYTE_PCH: frame_byte = {3'h0, s.pc[12:8]};
      csie_pkg::BYTE_IDX: frame_byte = s.idx;
      csie_pkg::BYTE_ACC: frame_byte = s.acc;
      default: frame_byte = {3'h7, s.condition_flag_reg};
    endcase
  endfunction : frame_byte

  // Address decode into the map regions.
  function automatic logic [2:0] region_of(input logic [12:0] a);
    if (a <= csie_pkg::IO_HI) begin
      region_of = csie_pkg::RG_IO;
    end else if (a <= csie_pkg::PZ_HI) begin
      region_of = csie_pkg::RG_PZROM;
    end else if (a <= csie_pkg::RAM_HI) begin
      region_of = csie_pkg::RG_RAM;
    end else if (a >= csie_pkg::ROM_LO && a <= csie_pkg::ROM_HI) begin
      region_of = csie_pkg::RG_ROM;
    end else if (a >= csie_pkg::SELF_LO && a <= csie_pkg::SELF_HI) begin
      region_of = csie_pkg::RG_SELF;
    end else if (a > csie_pkg::SELF_HI) begin
      region_of = csie_pkg::RG_UVEC;
    end else begin
      region_of = csie_pkg::RG_NONE;
    end
  endfunction : region_of

  // Starts a push of frame bytes 0..last, then vectors or jumps.
  function automatic csie_core_s start_push(input csie_core_s s, input logic [2:0] last,
                                            input logic tv, input logic [12:0] tgt);
    csie_core_s t;
    t = s;
    t.fsm = csie_pkg::ST_PUSH;
    t.k = 3'h0;
    t.ph = 2'h0;
    t.last = last;
    t.then_vec = tv;
    t.vec = tgt;
    t.jmp = tgt;
    start_push = t;
  endfunction : start_push

  // Starts a pull of frame bytes from top down to 0.
  function automatic csie_core_s start_pull(input csie_core_s s, input logic [2:0] top);
    csie_core_s t;
    t = s;
    t.fsm = csie_pkg::ST_PULL;
    t.k = top;
    t.ph = 2'h0;
    start_pull = t;
  endfunction : start_pull

  // ------------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------------
  // A bus write blocks commands so register writes never race the engine.
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & (~r.ack | ~I_CLK_EN);
  assign O_CMD_READY = I_CLK_EN & (r.fsm == csie_pkg::ST_IDLE) & ~I_AVS_WRITE;
  assign cmd_fire = I_CMD_VALID & O_CMD_READY;

  // Requests are masked by the flag bit only at the boundary decision.
  assign fall = r.irq_lvl & (r.s2 == r.s3) & ~r.s3;
  assign ext_req = r.ctrl[csie_pkg::CTRL_EXT_EN] &
                   (r.ext_latch | (r.ctrl[csie_pkg::CTRL_LEVEL] & ~r.irq_lvl));
  assign tmr_req = |(I_TIMER_FLAGS & I_TIMER_ENABLES);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    n = r;
    n.mem_rd = 1'b0;
    n.mem_wr = 1'b0;
    n.ack = 1'b0;
    res9 = 9'h000;
    half = 5'h00;
    // Pin synchroniser; a level counts once stages two and three agree.
    n.s1 = I_IRQ_N;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.irq_lvl = r.s3;
    end
    // Bus slave: answer one cycle after the request; writes need an idle engine.
    if ((I_AVS_READ | I_AVS_WRITE) && !r.ack &&
        (!I_AVS_WRITE || r.fsm == csie_pkg::ST_IDLE)) begin
      n.ack = 1'b1;
      n.rd_data = 32'h0000_0000;
      unique case (I_AVS_ADDRESS)
        csie_pkg::REG_ACC: n.rd_data[7:0] = r.acc;
        csie_pkg::REG_IDX: n.rd_data[7:0] = r.idx;
        csie_pkg::REG_CCR: n.rd_data[4:0] = r.condition_flag_reg;
        csie_pkg::REG_SP: n.rd_data[7:0] = {2'h3, r.sp};
        csie_pkg::REG_PC: n.rd_data[12:0] = r.pc;
        csie_pkg::REG_CTRL: n.rd_data[1:0] = r.ctrl;
        csie_pkg::REG_STAT: n.rd_data[4:0] = {r.fsm, r.irq_lvl, tmr_req, ext_req};
        default: n.rd_data = 32'h0000_0000;
      endcase
    end
    if (r.ack && I_AVS_WRITE) begin
      unique case (I_AVS_ADDRESS)
        csie_pkg::REG_ACC: n.acc = I_AVS_WRITEDATA[7:0];
        csie_pkg::REG_IDX: n.idx = I_AVS_WRITEDATA[7:0];
        csie_pkg::REG_CCR: n.condition_flag_reg = I_AVS_WRITEDATA[4:0];
        csie_pkg::REG_SP: n.sp = I_AVS_WRITEDATA[5:0];
        csie_pkg::REG_PC: n.pc = I_AVS_WRITEDATA[12:0];
        csie_pkg::REG_CTRL: n.ctrl = I_AVS_WRITEDATA[1:0];
        default: n.ctrl = r.ctrl;
      endcase
    end
    // Engine.
    unique case (r.fsm)
      csie_pkg::ST_IDLE: begin
        if (cmd_fire) begin
          unique case (csie_pkg::csie_op_e'(I_CMD_OP))
            csie_pkg::OP_END: begin
              // Requests seen mid-instruction are only acted on here.
              n.pc = I_CMD_ADDR;
              if (!r.condition_flag_reg[csie_pkg::CCR_I] && ext_req) begin
                n = start_push(n, csie_pkg::BYTE_CCR, 1'b1, csie_pkg::VEC_EXT);
              end else if (!r.condition_flag_reg[csie_pkg::CCR_I] && tmr_req) begin
                n = start_push(n, csie_pkg::BYTE_CCR, 1'b1, csie_pkg::VEC_TIMER);
              end
            end
            csie_pkg::OP_SOFT_INT: begin
              n.pc = I_CMD_ADDR;
              n = start_push(n, csie_pkg::BYTE_CCR, 1'b1, csie_pkg::VEC_SOFT);
            end
            csie_pkg::OP_ADD, csie_pkg::OP_ADC: begin
              res9 = {1'b0, r.acc} + {1'b0, I_CMD_DATA} +
                     {8'h00, (I_CMD_OP == csie_pkg::OP_ADC) & r.condition_flag_reg[csie_pkg::CCR_C]};
              half = {1'b0, r.acc[3:0]} + {1'b0, I_CMD_DATA[3:0]} +
                     {4'h0, (I_CMD_OP == csie_pkg::OP_ADC) & r.condition_flag_reg[csie_pkg::CCR_C]};
              n.acc = res9[7:0];
              n.condition_flag_reg[csie_pkg::CCR_H] = half[4];
              n.condition_flag_reg[csie_pkg::CCR_C] = res9[8];
            end
            csie_pkg::OP_SUB: begin
              res9 = {1'b0, r.acc} - {1'b0, I_CMD_DATA};
              n.acc = res9[7:0];
              n.condition_flag_reg[csie_pkg::CCR_C] = res9[8];
            end
            csie_pkg::OP_AND: begin
              res9 = {1'b0, r.acc & I_CMD_DATA};
              n.acc = res9[7:0];
            end
            csie_pkg::OP_LDA: begin
              res9 = {1'b0, I_CMD_DATA};
              n.acc = I_CMD_DATA;
            end
            csie_pkg::OP_LDX: begin
              res9 = {1'b0, I_CMD_DATA};
              n.idx = I_CMD_DATA;
            end
            csie_pkg::OP_ROL: begin
              res9 = {r.acc, r.condition_flag_reg[csie_pkg::CCR_C]};
              n.acc = res9[7:0];
              n.condition_flag_reg[csie_pkg::CCR_C] = res9[8];
            end
            csie_pkg::OP_BTB: n.condition_flag_reg[csie_pkg::CCR_C] = I_CMD_DATA[0];
            csie_pkg::OP_STACK_RST: n.sp = csie_pkg::SP_RESET;
            csie_pkg::OP_CLI: n.condition_flag_reg[csie_pkg::CCR_I] = 1'b0;
            csie_pkg::OP_SEI: n.condition_flag_reg[csie_pkg::CCR_I] = 1'b1;
            csie_pkg::OP_CALL: begin
              n = start_push(n, csie_pkg::BYTE_PCH, 1'b0, I_CMD_ADDR);
            end
            csie_pkg::OP_RTS: n = start_pull(n, csie_pkg::BYTE_PCH);
            csie_pkg::OP_INT_RET: n = start_pull(n, csie_pkg::BYTE_CCR);
          endcase
          // Result flags for every data-producing operation.
          if (I_CMD_OP inside {csie_pkg::OP_ADD, csie_pkg::OP_ADC, csie_pkg::OP_SUB,
                               csie_pkg::OP_AND, csie_pkg::OP_LDA, csie_pkg::OP_LDX,
                               csie_pkg::OP_ROL}) begin
            n.condition_flag_reg[csie_pkg::CCR_N] = res9[7];
            n.condition_flag_reg[csie_pkg::CCR_Z] = (res9[7:0] == 8'h00);
          end
        end
      end
      csie_pkg::ST_PUSH: begin
        if (r.ph == 2'h0) begin
          n.mem_addr = stack_addr(r.sp);
          n.mem_wdata = frame_byte(r, r.k);
          n.mem_wr = 1'b1;
          n.sp = r.sp - 6'h01;
          n.ph = 2'h1;
        end else if (r.k == r.last) begin
          n.ph = 2'h0;
          n.k = 3'h0;
          if (r.then_vec) begin
            // Mask is set after the flags were stacked with their old value.
            n.condition_flag_reg[csie_pkg::CCR_I] = 1'b1;
            n.fsm = csie_pkg::ST_VECTOR;
          end else begin
            n.pc = r.jmp;
            n.fsm = csie_pkg::ST_IDLE;
          end
        end else begin
          n.k = r.k + 3'h1;
          n.ph = 2'h0;
        end
      end
      csie_pkg::ST_PULL: begin
        if (r.ph == 2'h0) begin
          n.sp = r.sp + 6'h01;
          n.mem_addr = stack_addr(r.sp + 6'h01);
          n.mem_rd = 1'b1;
          n.ph = 2'h1;
        end else if (r.ph == 2'h1) begin
          n.ph = 2'h2;
        end else begin
          unique case (r.k)
            csie_pkg::BYTE_PCL: n.pc[7:0] = I_MEM_RDATA;
            csie_pkg::BYTE_PCH: n.pc[12:8] = I_MEM_RDATA[4:0];
            csie_pkg::BYTE_IDX: n.idx = I_MEM_RDATA;
            csie_pkg::BYTE_ACC: n.acc = I_MEM_RDATA;
            default: n.condition_flag_reg = I_MEM_RDATA[4:0];
          endcase
          n.ph = 2'h0;
          if (r.k == csie_pkg::BYTE_PCL) begin
            n.fsm = csie_pkg::ST_IDLE;
          end else begin
            n.k = r.k - 3'h1;
          end
        end
      end
      csie_pkg::ST_VECTOR: begin
        if (r.ph == 2'h0) begin
          n.mem_addr = r.vec + {10'h000, r.k};
          n.mem_rd = 1'b1;
          n.ph = 2'h1;
          // Entering the external service routine releases its latch.
          if (r.vec == csie_pkg::VEC_EXT && r.k == 3'h0) begin
            n.ext_latch = 1'b0;
          end
        end else if (r.ph == 2'h1) begin
          n.ph = 2'h2;
        end else if (r.k == 3'h0) begin
          n.vec_hi = I_MEM_RDATA[4:0];
          n.k = 3'h1;
          n.ph = 2'h0;
        end else begin
          n.pc = {r.vec_hi, I_MEM_RDATA};
          n.k = 3'h0;
          n.ph = 2'h0;
          n.fsm = csie_pkg::ST_IDLE;
        end
      end
    endcase
    // A new edge in the clearing cycle is kept.
    if (fall) begin
      n.ext_latch = 1'b1;
    end
    n.region = region_of(n.mem_addr);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Reset parks the engine on the reset vector with the mask set.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      r <= '0;
      r.fsm <= csie_pkg::ST_VECTOR;
      r.vec <= csie_pkg::VEC_RESET;
      r.condition_flag_reg <= csie_pkg::CCR_RESET;
      r.sp <= csie_pkg::SP_RESET;
      r.ctrl <= csie_pkg::CTRL_RESET;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.s3 <= 1'b1;
      r.irq_lvl <= 1'b1;
    end else if (I_CLK_EN) begin
      r <= n;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign O_AVS_READDATA = r.rd_data;
  assign O_MEM_ADDR = r.mem_addr;
  assign O_MEM_RD = r.mem_rd;
  assign O_MEM_WR = r.mem_wr;
  assign O_MEM_WDATA = r.mem_wdata;
  assign O_MEM_REGION = r.region;
  assign O_ACC = r.acc;
  assign O_IDX = r.idx;
  assign O_CCR = r.condition_flag_reg;
  assign O_SP = {2'h3, r.sp};
  assign O_PC = r.pc;
endmodule : csie_core

// *** verif/csie_core_asserts.sv ***
// Concurrent checks on the core's command, memory and state ports.
`timescale 1ns/1ps
module csie_core_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_CMD_VALID,
  input wire logic [3:0] I_CMD_OP,
  input wire logic O_CMD_READY,
  input wire logic [2:0] I_TIMER_FLAGS,
  input wire logic [2:0] I_TIMER_ENABLES,
  input wire logic [12:0] O_MEM_ADDR,
  input wire logic O_MEM_RD,
  input wire logic O_MEM_WR,
  input wire logic [2:0] O_MEM_REGION,
  input wire logic [4:0] O_CCR,
  input wire logic [7:0] O_SP
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  logic take_w;
  // A command counts only on an edge where it is both offered and accepted.
  assign take_w = I_CMD_VALID && O_CMD_READY;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_push_post_dec: assert property (O_MEM_WR |-> O_MEM_ADDR[5:0] == O_SP[5:0] + 6'h01)
    else $error("stack pointer not moved down after a push");
  a_stack_page: assert property (O_MEM_WR |-> O_MEM_ADDR[12:6] == csie_pkg::STACK_PAGE)
    else $error("push outside the stack page");
  a_push_ram: assert property (O_MEM_WR |-> O_MEM_REGION == csie_pkg::RG_RAM)
    else $error("push not in ram region");
  a_vec_region: assert property (O_MEM_RD && O_MEM_ADDR >= 13'h1FF0 |-> O_MEM_REGION == 3'h6)
    else $error("vector read not in user vector region");
  a_masked_end: assert property (take_w && I_CMD_OP == csie_pkg::OP_END && O_CCR[3]
    |=> !O_MEM_WR [*3])
    else $error("entry taken while masked");
  a_timer_entry: assert property (take_w && I_CMD_OP == csie_pkg::OP_END && !O_CCR[3]
    && (|(I_TIMER_FLAGS & I_TIMER_ENABLES)) |-> ##[1:3] O_MEM_WR)
    else $error("enabled timer request not entered");
  a_soft_entry: assert property (take_w && I_CMD_OP == csie_pkg::OP_SOFT_INT |-> ##[1:3] O_MEM_WR)
    else $error("software interrupt did not stack");
  a_mask_vector: assert property (O_MEM_RD && O_MEM_ADDR[12:3] == 10'h3FF
    && !O_MEM_ADDR[0] |-> O_CCR[3])
    else $error("vector fetched with mask clear");
  a_vec_pair: assert property (O_MEM_RD && O_MEM_ADDR[12:4] == 9'h1FF && !O_MEM_ADDR[0]
    |-> ##3 O_MEM_RD && O_MEM_ADDR[0])
    else $error("vector low byte not fetched");
  a_stack_reset: assert property (take_w && I_CMD_OP == csie_pkg::OP_STACK_RST |=> O_SP == 8'hFF)
    else $error("stack reset did not load 00FF");
endmodule : csie_core_asserts
bind csie_core csie_core_asserts u_chk (.*);

// *** verif/csie_core_tb.sv ***
// Self-checking bench for the core state and interrupt entry unit.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module csie_core_tb;
  logic clk, rst_n, ce, rd, wr, cv, irq_n, mrd, mwr, wq, rdy;
  logic [4:0] adr, condition_flag_reg;
  logic [31:0] wd, rdd, r;
  logic [3:0] op;
  logic [7:0] cd, mwd, mrdat, acc, idx, sp;
  logic [12:0] ca, maddr, pc;
  logic [2:0] tf, te, reg3;
  int n_tests, n_mismatch;
  csie_core DUT (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_CLK_EN(ce),
    .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .O_AVS_READDATA(rdd), .O_AVS_WAITREQUEST(wq), .I_CMD_VALID(cv), .I_CMD_OP(op),
    .I_CMD_DATA(cd), .I_CMD_ADDR(ca), .O_CMD_READY(rdy), .I_IRQ_N(irq_n),
    .I_TIMER_FLAGS(tf), .I_TIMER_ENABLES(te), .O_MEM_ADDR(maddr), .O_MEM_RD(mrd),
    .O_MEM_WR(mwr), .O_MEM_WDATA(mwd), .I_MEM_RDATA(mrdat), .O_MEM_REGION(reg3),
    .O_ACC(acc), .O_IDX(idx), .O_CCR(condition_flag_reg), .O_SP(sp), .O_PC(pc));
  csie_mem_model u_mem (.i_clk(clk), .i_addr(maddr), .i_rd(mrd), .i_wr(mwr),
    .i_wdata(mwd), .o_rdata(mrdat));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Ready is looked at on the rising edge itself; only the watchdog ends a long wait.
  task automatic until_ready();
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
  endtask : until_ready
  // The request stands until the edge that sees waitrequest low, and read data is taken there.
  task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    r = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : avs
  // Valid drops right after the accepting edge, then the engine is awaited.
  task automatic cmd(input logic [3:0] o, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    cv <= 1'b1;
    op <= o;
    cd <= d;
    ca <= a;
    until_ready();
    cv <= 1'b0;
    until_ready();
  endtask : cmd
  // Limit of 20000 cycles is far above the few hundred cycles the sequence needs.
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, rd, wr, cv, adr, wd, op, cd, ca, tf, te} = '0;
    irq_n = 1'b1;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    until_ready();
    `CHK({pc, condition_flag_reg, sp, reg3}, {13'h1234, 5'h08, 8'hFF, 3'h6})
    avs(1'b0, csie_pkg::REG_SP, 32'h0);
    `CHK(r, 32'h000000FF)
    avs(1'b1, csie_pkg::REG_STAT, 32'h000000FF);
    avs(1'b0, csie_pkg::REG_STAT, 32'h0);
    `CHK(r, 32'h00000004)
    avs(1'b0, 5'h1C, 32'h0);
    `CHK(r, 32'h00000000)
    avs(1'b1, csie_pkg::REG_ACC, 32'h000000A5);
    avs(1'b0, csie_pkg::REG_ACC, 32'h0);
    `CHK(r, 32'h000000A5)
    // A low clock enable must freeze the core even with a command on offer.
    ce <= 1'b0;
    cv <= 1'b1;
    op <= csie_pkg::OP_LDA;
    cd <= 8'h3C;
    repeat (3) @(posedge clk);
    `CHK({rdy, acc}, {1'b0, 8'hA5})
    cv <= 1'b0;
    ce <= 1'b1;
    $display("Test reset and bus done");
    cmd(csie_pkg::OP_LDA, 13'h0, 8'h0F);
    cmd(csie_pkg::OP_ADD, 13'h0, 8'h01);
    `CHK({acc, condition_flag_reg}, {8'h10, 5'h18})
    cmd(csie_pkg::OP_ADD, 13'h0, 8'hF0);
    `CHK({acc, condition_flag_reg}, {8'h00, 5'h0B})
    cmd(csie_pkg::OP_ADC, 13'h0, 8'h80);
    `CHK({acc, condition_flag_reg}, {8'h81, 5'h0C})
    cmd(csie_pkg::OP_SUB, 13'h0, 8'h82);
    `CHK({acc, condition_flag_reg}, {8'hFF, 5'h0D})
    cmd(csie_pkg::OP_AND, 13'h0, 8'h0F);
    `CHK({acc, condition_flag_reg}, {8'h0F, 5'h09})
    cmd(csie_pkg::OP_ROL, 13'h0, 8'h0);
    `CHK({acc, condition_flag_reg}, {8'h1F, 5'h08})
    cmd(csie_pkg::OP_BTB, 13'h0, 8'h01);
    `CHK(condition_flag_reg, 5'h09)
    cmd(csie_pkg::OP_LDA, 13'h0, 8'hFF);
    `CHK({acc, condition_flag_reg}, {8'hFF, 5'h0D})
    cmd(csie_pkg::OP_LDX, 13'h0, 8'h5A);
    `CHK({idx, condition_flag_reg}, {8'h5A, 5'h09})
    $display("Test flags done");
    cmd(csie_pkg::OP_CLI, 13'h0, 8'h0);
    cmd(csie_pkg::OP_CALL, 13'h0200, 8'h0);
    `CHK({pc, sp}, {13'h0200, 8'hFD})
    cmd(csie_pkg::OP_RTS, 13'h0, 8'h0);
    `CHK({pc, sp}, {13'h1234, 8'hFF})
    $display("Test call done");
    cmd(csie_pkg::OP_SEI, 13'h0, 8'h0);
    tf <= 3'b010;
    te <= 3'b010;
    cmd(csie_pkg::OP_END, 13'h0300, 8'h0);
    `CHK({pc, sp}, {13'h0300, 8'hFF})
    cmd(csie_pkg::OP_CLI, 13'h0, 8'h0);
    cmd(csie_pkg::OP_END, 13'h0301, 8'h0);
    `CHK({pc, sp, condition_flag_reg}, {13'h0A80, 8'hFA, 5'h09})
    `CHK({u_mem.mem[255], u_mem.mem[254], u_mem.mem[253], u_mem.mem[252],
      u_mem.mem[251]}, {8'h01, 8'h03, 8'h5A, 8'hFF, 8'hE1})
    tf <= 3'b000;
    cmd(csie_pkg::OP_INT_RET, 13'h0, 8'h0);
    `CHK({pc, sp, condition_flag_reg}, {13'h0301, 8'hFF, 5'h01})
    $display("Test timer entry done");
    tf <= 3'b101;
    cmd(csie_pkg::OP_END, 13'h0302, 8'h0);
    `CHK(pc, 13'h0302)
    te <= 3'b111;
    irq_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmd(csie_pkg::OP_END, 13'h0303, 8'h0);
    `CHK({pc, sp}, {13'h0B90, 8'hFA})
    tf <= 3'b000;
    // Pin still low but the edge latch is spent: only level mode raises a request.
    avs(1'b0, csie_pkg::REG_STAT, 32'h0);
    `CHK(r, 32'h00000000)
    avs(1'b1, csie_pkg::REG_CTRL, 32'h00000003);
    avs(1'b0, csie_pkg::REG_STAT, 32'h0);
    `CHK(r, 32'h00000001)
    avs(1'b1, csie_pkg::REG_CTRL, 32'h00000001);
    irq_n <= 1'b1;
    cmd(csie_pkg::OP_INT_RET, 13'h0, 8'h0);
    `CHK({pc, condition_flag_reg}, {13'h0303, 5'h01})
    $display("Test priority done");
    cmd(csie_pkg::OP_SEI, 13'h0, 8'h0);
    cmd(csie_pkg::OP_SOFT_INT, 13'h0400, 8'h0);
    `CHK({pc, sp}, {13'h0CA0, 8'hFA})
    cmd(csie_pkg::OP_STACK_RST, 13'h0, 8'h0);
    `CHK(sp, 8'hFF)
    $display("Test software entry done");
    stop_test();
  end
endmodule : csie_core_tb

// *** verif/csie_mem_model.sv ***
// Memory partner model: byte store with vector pairs and one-cycle read latency.
`timescale 1ns/1ps
module csie_mem_model (
  input wire logic i_clk,
  input wire logic [12:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:8191];
  // ----------------------------------------------------------------
  // Contents
  // ----------------------------------------------------------------
  // Each vector pair holds its high byte at the lower address.
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
    mem[13'h1FFE] = 8'h12;
    mem[13'h1FFF] = 8'h34;
    mem[13'h1FFC] = 8'h0C;
    mem[13'h1FFD] = 8'hA0;
    mem[13'h1FFA] = 8'h0B;
    mem[13'h1FFB] = 8'h90;
    mem[13'h1FF8] = 8'h0A;
    mem[13'h1FF9] = 8'h80;
    o_rdata = 8'h00;
  end
  // Outside a read the line toggles, so stale data never looks valid.
  always @(posedge i_clk) begin
    if (i_wr)
      mem[i_addr] <= i_wdata;
    o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
  end
endmodule : csie_mem_model
